// ===== src/pdt_regs.vh
/*
 Register offsets, field positions, reset values and timing counts
 of the prescaled down timer. Assumes an APB slave with 32-bit data.
*/
`ifndef PDT_REGS_VH
`define PDT_REGS_VH
`define PDT_OFF_PSC 10'h0D2
`define PDT_OFF_CNT 10'h0D3
`define PDT_OFF_CTL 10'h0D4
`define PDT_BUS_STOP 12'h0E0
`define PDT_PSC_RST 7'h7F
`define PDT_CNT_RST 8'hFF
`define PDT_CTL_RST 8'h00
`define PDT_BIT_ZERO 7
`define PDT_BIT_IEN 6
`define PDT_BIT_RSV5 5
`define PDT_BIT_RSV4 4
`define PDT_BIT_RUN 3
`define PDT_DIV_FIXED 12
`define PDT_DIV_LAST 4'hB
`endif

// ===== src/pdt_tap_tick.v
/*
 Tap tick generator: pulses when the selected prescaler bit falls; tap 0 pulses on every prescaler step.
 Assumes the prescaler value is a registered down count.
*/
`timescale 1ns/1ps
`include "pdt_regs.vh"
module pdt_tap_tick
#(
   parameter PW = 7
)
(
   // Clock and reset
   input wire pclk,
   input wire presetn,
   input wire ce,
   // Prescaler view
   input wire [PW-1:0] psc_cur,
   input wire [PW-1:0] psc_nxt,
   input wire psc_step,
   input wire [2:0] tap_select,
   // Tick out
   output wire counter_tick
);
   wire [PW:0] ext_cur;
   wire [PW:0] ext_nxt;
   // Tap n ticks every 2^n steps; tap 0 is every prescaler step
   assign ext_cur = {psc_cur, 1'b1};
   assign ext_nxt = {psc_nxt, 1'b0};
   assign counter_tick = psc_step & ext_cur[tap_select] & ~ext_nxt[tap_select];
endmodule // pdt_tap_tick

// ===== src/pdt_timer.v
/*
 Prescaled down timer: divide-by-twelve, 7-bit prescaler, 8-bit
 down counter, zero flag and interrupt level, APB register slave.
 Assumes pclk is the core internal clock and APB is synchronous.
*/
`timescale 1ns/1ps
`include "pdt_regs.vh"
module pdt_timer
#(
   parameter PW = 7,
   parameter CW = 8
)
(
   // Clock, reset, enable
   input wire pclk,
   input wire presetn,
   input wire ce,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   // Power modes
   input wire stop_mode,
   // Interrupt
   output wire timer_irq,
   output wire wake_req
);
   // Divider and prescaler state
   reg [3:0] div_q;
   reg [3:0] div_d;
   reg [PW-1:0] psc_q;
   reg [PW-1:0] psc_d;

   // Counter and status state
   reg [CW-1:0] cnt_q;
   reg [CW-1:0] cnt_d;
   reg zero_flag_q;
   reg zero_flag_d;
   reg underflow_irq_enable_q;
   reg underflow_irq_enable_d;
   reg prescaler_run_q;
   reg prescaler_run_d;
   reg [2:0] tap_select_q;
   reg [2:0] tap_select_d;

   // Read path state
   reg [31:0] rdata_d;
   reg rd_loaded_q;
   reg rd_loaded_d;

   // Bus decode
   wire run_en;
   wire [9:0] word_idx;
   wire aligned;
   wire hit_psc;
   wire hit_cnt;
   wire hit_ctl;
   wire mapped;
   wire acc;
   wire done;
   wire wr;
   wire wr_psc;
   wire wr_cnt;
   wire wr_ctl;
   wire rd_load;
   // Timing chain
   wire div_tick;
   wire psc_step;
   wire counter_tick;
   wire cnt_step;
   wire [PW-1:0] psc_dec;
   wire psc_at_zero;
   wire cnt_at_zero;
   wire cnt_at_one;
   wire cnt_write_zero;
   wire underflow_evt;
   // Status byte as software sees it
   wire [7:0] ctl_view;

   // Stop mode freezes everything, same as clock enable low
   assign run_en = ce & ~stop_mode;

   // Register numbers are word indices; only aligned words decode
   assign word_idx = paddr[11:2];
   assign aligned = (paddr[1:0] == 2'b00);
   assign hit_psc = aligned & (word_idx == `PDT_OFF_PSC);
   assign hit_cnt = aligned & (word_idx == `PDT_OFF_CNT);
   assign hit_ctl = aligned & (word_idx == `PDT_OFF_CTL);
   assign mapped = hit_psc | hit_cnt | hit_ctl;
   assign acc = psel & penable;
   assign done = acc & pready;
   assign wr = done & pwrite;
   assign wr_psc = wr & hit_psc;
   assign wr_cnt = wr & hit_cnt;
   assign wr_ctl = wr & hit_ctl;

   // A read waits for its latched data, so a read stalled in setup
   // by stop or a low enable never returns stale data
   assign rd_load = psel & ~pwrite & run_en & ~rd_loaded_q;
   assign pready = run_en & (pwrite | rd_loaded_q);
   assign pslverr = acc & ~mapped;

   assign div_tick = (div_q == `PDT_DIV_LAST);
   assign psc_step = div_tick & prescaler_run_q;
   assign psc_at_zero = (psc_q == {PW{1'b0}});
   assign psc_dec = psc_at_zero ? `PDT_PSC_RST : psc_q - 1'b1;

   assign cnt_step = counter_tick & prescaler_run_q;
   assign cnt_at_zero = (cnt_q == {CW{1'b0}});
   assign cnt_at_one = (cnt_q == {{(CW-1){1'b0}}, 1'b1});
   assign cnt_write_zero = (pwdata[CW-1:0] == {CW{1'b0}});
   // A counter write in the same cycle replaces the decrement
   assign underflow_evt = cnt_step & cnt_at_one & ~wr_cnt;

   // Divide-by-twelve phase counter
   always @*
   begin
      div_d = div_q + 4'h1;
      if (div_tick)
         div_d = 4'h0;
   end

   // Divider free-runs whatever the run bit says
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         div_q <= 4'h0;
      else if (run_en)
         div_q <= div_d;
   end

   // Run clear holds the prescaler at its reload value
   always @*
   begin
      psc_d = psc_q;
      if (!prescaler_run_q)
         psc_d = `PDT_PSC_RST;
      else if (wr_psc)
         psc_d = pwdata[PW-1:0];
      else if (psc_step)
         psc_d = psc_dec;
   end

   // Counter tick on the falling edge of the chosen tap
   pdt_tap_tick #(.PW(PW)) u_tap
   (
      .pclk(pclk),
      .presetn(presetn),
      .ce(run_en),
      .psc_cur(psc_q),
      .psc_nxt(psc_dec),
      .psc_step(psc_step),
      .tap_select(tap_select_q),
      .counter_tick(counter_tick)
   );

   // Prescaler register
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         psc_q <= `PDT_PSC_RST;
      else if (run_en)
         psc_q <= psc_d;
   end

   // Counter next value; a software write has priority
   always @*
   begin
      cnt_d = cnt_q;
      if (wr_cnt)
         cnt_d = pwdata[CW-1:0];
      else if (cnt_step)
      begin
         if (cnt_at_zero)
            cnt_d = `PDT_CNT_RST;
         else
            cnt_d = cnt_q - 1'b1;
      end
   end

   // Counter register
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cnt_q <= `PDT_CNT_RST;
      else if (run_en)
         cnt_q <= cnt_d;
   end

   // Hardware set wins over a software clear in the same cycle
   always @*
   begin
      zero_flag_d = zero_flag_q;
      if (wr_ctl)
         zero_flag_d = pwdata[`PDT_BIT_ZERO];
      if (wr_cnt && cnt_write_zero)
         zero_flag_d = 1'b1;
      if (underflow_evt)
         zero_flag_d = 1'b1;
   end

   // Zero flag register
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         zero_flag_q <= 1'b0;
      else if (run_en)
         zero_flag_q <= zero_flag_d;
   end

   // Control fields change only on a status write
   always @*
   begin
      underflow_irq_enable_d = underflow_irq_enable_q;
      prescaler_run_d = prescaler_run_q;
      tap_select_d = tap_select_q;
      if (wr_ctl)
      begin
         underflow_irq_enable_d = pwdata[`PDT_BIT_IEN];
         prescaler_run_d = pwdata[`PDT_BIT_RUN];
         tap_select_d = pwdata[2:0];
      end
   end

   // Interrupt enable register
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         underflow_irq_enable_q <= 1'b0;
      else if (run_en)
         underflow_irq_enable_q <= underflow_irq_enable_d;
   end

   // Run bit register
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prescaler_run_q <= 1'b0;
      else if (run_en)
         prescaler_run_q <= prescaler_run_d;
   end

   // Tap select register
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         tap_select_q <= 3'h0;
      else if (run_en)
         tap_select_q <= tap_select_d;
   end

   // Level output; stays up until software clears flag or enable
   assign timer_irq = zero_flag_q & underflow_irq_enable_q;
   assign wake_req = timer_irq;

   assign ctl_view = {zero_flag_q, underflow_irq_enable_q, 2'b00, prescaler_run_q,
                      tap_select_q};

   // Read mux, zero for any unmapped word
   always @*
   begin
      rdata_d = 32'h00000000;
      if (hit_psc)
         rdata_d = {25'h0000000, psc_q};
      else if (hit_cnt)
         rdata_d = {24'h000000, cnt_q};
      else if (hit_ctl)
         rdata_d = {24'h000000, ctl_view};
   end

   // One load per read transfer, cleared when it completes
   always @*
   begin
      rd_loaded_d = rd_loaded_q;
      if (done || !psel)
         rd_loaded_d = 1'b0;
      else if (rd_load)
         rd_loaded_d = 1'b1;
   end

   // Read handshake register
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rd_loaded_q <= 1'b0;
      else if (run_en)
         rd_loaded_q <= rd_loaded_d;
   end

   // Data output from a flop, loaded once per read
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h00000000;
      else if (rd_load)
         prdata <= rdata_d;
   end
endmodule // pdt_timer

// ===== testbench/pdt_timer_assertions.sv
/* Port checker for the prescaled down timer.
 Assumes binding to pdt_timer and 20 MHz pclk. */
`timescale 1ns/1ps
module pdt_timer_chk (
   // Clock and control
   input wire pclk,
   input wire presetn,
   input wire ce,
   input wire stop_mode,
   // APB
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   // Interrupt
   input wire timer_irq,
   input wire wake_req
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire acc = psel && penable;
   chk_wake_same: assert property (wake_req == timer_irq)
      else $error("wake differs");
   chk_stop_ready: assert property (pready |-> (ce && !stop_mode))
      else $error("ready wrong");
   chk_stop_hold: assert property (stop_mode |=> $stable(timer_irq))
      else $error("irq moved in stop");
   chk_irq_reset: assert property ($rose(presetn) |-> !timer_irq)
      else $error("irq after reset");
   chk_irq_held: assert property (timer_irq && !(acc && pwrite && paddr == 12'h350)
      |=> timer_irq)
      else $error("irq dropped");
   chk_psc_msb: assert property (acc && pready && !pwrite && paddr == 12'h348
      |-> !prdata[7])
      else $error("prescaler msb set");
   chk_ctl_rsv: assert property (acc && pready && !pwrite && paddr == 12'h350
      |-> prdata[5:4] == 2'h0)
      else $error("reserved bits set");
   chk_bad_addr: assert property (acc && paddr > 12'h350 |-> pslverr)
      else $error("no error response");
endmodule // pdt_timer_chk
bind pdt_timer pdt_timer_chk u_chk (.pclk, .presetn, .ce, .stop_mode, .psel, .penable,
   .pwrite, .paddr, .prdata, .pready, .pslverr, .timer_irq, .wake_req);

// ===== testbench/pdt_timer_tb.sv
/* Bench for the prescaled down timer over APB.
 Assumes zero-wait APB while running, ce high except during the stop test. */
`timescale 1ns/1ps
module pdt_timer_tb;
   reg pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, stop_mode = 0;
   reg [11:0] paddr = 0;
   reg [31:0] pwdata = 0, rd, p1;
   wire [31:0] prdata;
   wire pready, pslverr, timer_irq, wake_req;
   integer bad_count = 0, checks = 0, i, n, s;
   localparam [11:0] A_PSC = 12'h348;
   localparam [11:0] A_CNT = 12'h34C;
   localparam [11:0] A_CTL = 12'h350;
   localparam [11:0] A_BAD = 12'h380;
   pdt_timer uut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .stop_mode, .timer_irq, .wake_req);
   initial forever #25 pclk = ~pclk;
   task report_and_stop;
   begin
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   end
   endtask
   task chk(input [31:0] s, input [31:0] e);
   begin
      checks++;
      if (s !== e)
      begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   end
   endtask
   task xfer(input w, input [11:0] a, input [31:0] d);
      integer k;
      reg ok;
   begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      ok = 1'b0;
      while (!ok && k < 20)
      begin
         @(negedge pclk);
         ok = (pready === 1'b1);
         rd = prdata;
         k++;
         @(posedge pclk);
      end
      psel <= 1'b0;
      penable <= 1'b0;
      if (!ok)
      begin
         bad_count++;
         report_and_stop;
      end
      @(posedge pclk);
   end
   endtask
   task wr(input [11:0] a, input [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task rdc(input [11:0] a, input [31:0] e);
   begin
      xfer(1'b0, a, 0);
      chk(rd, e);
   end
   endtask
   task irq_is(input e);
   begin
      #1;
      chk(timer_irq, e);
      @(posedge pclk);
   end
   endtask
   initial
   begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdc(A_PSC, 32'h7F);
      rdc(A_CNT, 32'hFF);
      rdc(A_CTL, 32'h00);
      rdc(A_BAD, 32'h00);
      repeat (40) @(posedge pclk);
      rdc(A_PSC, 32'h7F);
      rdc(A_CNT, 32'hFF);
      $display("reset and idle test done");
      wr(A_CNT, 0);
      rdc(A_CTL, 32'h80);
      wr(A_CTL, 32'hC0);
      irq_is(1'b1);
      wr(A_CTL, 32'h40);
      irq_is(1'b0);
      $display("flag test done");
      for (i = 0; i < 6; i += 5)
      begin
         wr(A_CTL, 32'h08);
         wr(A_PSC, i);
         xfer(1'b0, A_PSC, 0);
         p1 = rd;
         chk(p1 == i || p1 == ((i + 127) % 128), 1);
         repeat (9) @(posedge pclk);
         rdc(A_PSC, (p1 + 32'h7F) & 32'h7F);
      end
      $display("prescaler test done");
      for (n = 0; n < 8; n++)
      begin
         wr(A_CTL, 32'h48 + n);
         wr(A_PSC, 32'h7F);
         wr(A_CNT, 32'h01);
         i = 0;
         while (timer_irq !== 1'b1 && i < 2000)
         begin
            @(negedge pclk);
            i++;
         end
         if (i == 2000)
         begin
            bad_count++;
            report_and_stop;
         end
         @(posedge pclk);
         s = (n == 0) ? 1 : (1 << (n - 1));
         chk(i >= 12 * s - 16 && i <= 12 * s + 14, 1);
         rdc(A_CNT, 32'h00);
         rdc(A_CTL, 32'hC8 + n);
         if (n == 0)
         begin
            repeat (12) @(posedge pclk);
            rdc(A_CNT, 32'hFF);
         end
      end
      $display("tap test done");
      wr(A_CTL, 32'h48);
      wr(A_CNT, 32'h80);
      stop_mode <= 1'b1;
      repeat (300) @(posedge pclk);
      stop_mode <= 1'b0;
      ce <= 1'b0;
      repeat (100) @(posedge pclk);
      ce <= 1'b1;
      @(posedge pclk);
      xfer(1'b0, A_CNT, 0);
      chk(rd == 32'h80 || rd == 32'h7F, 1);
      $display("stop test done");
      report_and_stop;
   end
endmodule // pdt_timer_tb
